// ===== src/ssr_status_srq.sv
// Status record and service-request marking for a loop interface.
// Assumes loop messages arrive one per cycle on msg_valid, already
// decoded; serial side events arrive as one-cycle pulses.
//
// Summary of operation
// RULE1: SB1 bit 6 shows originated request.
// RULE2: Parity error sets SB2 bit 7.
// RULE3: Frame error sets SB2 bit 6.
// RULE4: Overrun sets SB2 bit 5, autodisconnects.
// RULE5: Dropped receive data sets SB2 bit 4.
// RULE6: SB2 low bits are live buffer levels.
// RULE7: SB3 bit 7: RTS false, CTS true.
// RULE8: Manual key bit 6, break bit 4.
// RULE9: SB3 bit 5 autodisconnect, bit 3 remote.
// RULE10: Remote syntax error sets SB3 bit 2.
// RULE11: SB3 bit 1 software handshake blocking.
// RULE12: SB3 bit 0 hardware handshake blocking.
// RULE13: Fourth status byte is reserved.
// RULE14: No request without global enable bit.
// RULE15: Only enabled conditions raise status requests. The code lets the manual key raise one with only the global enable bit set.
// RULE16: Reset loads enables by default switch.
// RULE17: Mark next data, end, identify message.
// RULE18: Keep marking until change or status.
// RULE19: Idle loop may send own identify request.
// RULE20: Universal commands cancel asynchronous permission.
// RULE21: Controller treats both request forms alike.
// RULE22: SB1 shows highest priority condition only.
`timescale 1ns/1ps
`include "ssr_consts.svh"
module ssr_status_srq (
  input  wire logic            clk,              // Device clock
  input  wire logic            nrst,             // Async reset, low
  input  wire logic            default_switch_open, // Enable set select
  input  wire logic            parity_err,       // Parity error pulse
  input  wire logic            frame_err,        // Frame error pulse
  input  wire logic            overrun_err,      // Overrun pulse
  input  wire logic            rx_dropped,       // Rx data lost pulse
  input  wire logic            rx_full,          // Rx buffer full
  input  wire logic            rx_nempty,        // Rx buffer has data
  input  wire logic            tx_nfull,         // Tx buffer not full
  input  wire logic            tx_empty,         // Tx buffer empty
  input  wire logic            rts_out,          // Own request to send
  input  wire logic            cts_in,           // Partner clear to send
  input  wire logic            manual_request_key, // Key press pulse
  input  wire logic            break_rx,         // Break received pulse
  input  wire logic            remote_mode,      // Remote mode level
  input  wire logic            syntax_err,       // Syntax error pulse
  input  wire logic            sw_hs_block,      // Sw handshake blocks
  input  wire logic            sw_hs_redef,      // Sw handshake redefined
  input  wire logic            hw_hs_block,      // Hw handshake blocks
  input  wire logic            autodisc_clear,   // Leave autodisconnect
  input  wire logic            ctrl_wr,          // Enable register write
  input  wire logic [1:0]      ctrl_sel,         // 0 a, 1 b, 2 c
  input  wire logic [3:0]      ctrl_wdata,       // Enable write data
  input  wire logic            status_sent,      // Status answered pulse
  input  wire logic            msg_valid,        // Loop message present
  input  wire ssr_pkg::ssr_msg_t msg_kind,       // Message class
  input  wire logic            msg_srq_in,       // Incoming srq bit
  input  wire logic            cmd_ear,          // Enable async requests
  input  wire logic            cmd_universal,    // Other universal cmd
  input  wire logic            loop_idle,        // Loop is idle
  input  wire logic            async_ack,        // Own identify taken
  output logic                 msg_srq_out,      // Outgoing srq bit
  output logic                 async_idy_req,    // Send own identify
  output logic                 autodisconnect_q, // Serial side stopped
  output logic [7:0]           system_condition_status, // Byte 1
  output logic [7:0]           buffer_error_status,     // Byte 2
  output logic [7:0]           line_mode_status,        // Byte 3
  output logic [7:0]           spare_status,            // Byte 4
  output logic [3:0]           request_enable_ctrl_a,   // Enables a
  output logic [3:0]           request_enable_ctrl_b,   // Enables b
  output logic [3:0]           request_enable_ctrl_c    // Enables c
);

  ////////////////////////////////////////////////////////////////////
  // State
  // Enables load once, on the first edge after reset; a write that
  // lands on that edge is lost, so software waits one cycle.
  typedef enum {SSR_LD_PENDING, SSR_LD_DONE} ssr_ld_t;
  typedef struct packed {
    logic [3:0] ena;
    logic [3:0] enb;
    logic [3:0] enc;
    logic       loaded;
    logic       autodisc;
    logic       sw_block;
    logic       srq;
    logic       srq_ack;
    logic       async_ok;
    logic [5:0] prev_cond;
    logic [7:0] sb1;
    logic [7:0] sb2;
    logic [7:0] sb3;
  } ssr_st_t;
  ssr_st_t st_q;
  ssr_st_t st_d;
  ssr_ld_t ld;

  // Sticky event flags: parity, frame, overrun, dropped, key,
  // break, syntax
  logic [6:0] ev_set;
  logic [6:0] ev_clr;
  logic [6:0] ev_q;

  // Priority encoder of the system byte
  // The transmit buffer is always either full or not, so one of the
  // lowest codes always stands; the empty code only guards the gaps.
  function automatic logic [5:0] sb1_code(
    input logic ad, input logic key, input logic brk,
    input logic derr, input logic rnf, input logic tnf,
    input logic tfull);
    logic [5:0] c;
    c = `SSR_CODE_NONE;
    if (ad) begin
      c = `SSR_CODE_NO_ROOM;
    end else if (key) begin
      c = `SSR_CODE_KEYBOARD;
    end else if (brk) begin
      c = `SSR_CODE_DEVICE;
    end else if (derr) begin
      c = `SSR_CODE_DATA_ERR;
    end else if (rnf) begin
      c = `SSR_CODE_RDY_SEND;
    end else if (tnf) begin
      c = `SSR_CODE_RDY_RECV;
    end else if (tfull) begin
      c = `SSR_CODE_NOT_RDY;
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Sticky bits cleared after status answer
  assign ev_set = {syntax_err, break_rx, manual_request_key,
                   rx_dropped, overrun_err, frame_err, parity_err};
  assign ev_clr = {7{status_sent}};

  ssr_sticky u_sticky (
    .clk    (clk),
    .nrst   (nrst),
    .set    (ev_set),
    .clr    (ev_clr),
    .flag_q (ev_q)
  );

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic       derr;
    logic [5:0] cond;
    logic       want;
    logic       any_en;
    derr = 1'b0;
    cond = '0;
    want = 1'b0;
    any_en = 1'b0;
    st_d = st_q;
    ld = st_q.loaded ? SSR_LD_DONE : SSR_LD_PENDING;

    // Enable registers: default set after reset, then writes
    unique case (ld)
      SSR_LD_PENDING: begin
        st_d.loaded = 1'b1;
        if (default_switch_open) begin                 // [RULE16]
          st_d.ena = `SSR_RST_CTRL_A_OPEN;
          st_d.enb = `SSR_RST_CTRL_B_OPEN;
          st_d.enc = `SSR_RST_CTRL_C_OPEN;
        end else begin
          st_d.ena = `SSR_RST_CTRL_A_CLOSED;
          st_d.enb = `SSR_RST_CTRL_B_CLOSED;
          st_d.enc = `SSR_RST_CTRL_C_CLOSED;
        end
      end
      SSR_LD_DONE: begin
        if (ctrl_wr) begin
          unique case (ctrl_sel)
            2'd0: st_d.ena = ctrl_wdata;
            2'd1: st_d.enb = ctrl_wdata;
            2'd2: st_d.enc = ctrl_wdata;
            default: st_d.ena = st_q.ena;
          endcase
        end
      end
    endcase

    // Autodisconnect on overrun, held until released
    // An overrun in the cycle of a release keeps the side stopped
    if (overrun_err) begin                             // [RULE4]
      st_d.autodisc = 1'b1;
    end else if (autodisc_clear) begin
      st_d.autodisc = 1'b0;
    end

    // Software handshake block: set wins over redefinition
    if (sw_hs_block) begin                             // [RULE11]
      st_d.sw_block = 1'b1;
    end else if (sw_hs_redef) begin
      st_d.sw_block = 1'b0;
    end

    // Second byte
    // Sticky bits show one cycle after the flag bank sets them
    st_d.sb2 = '0;
    st_d.sb2[`SSR_SB2_PARITY]   = ev_q[0];             // [RULE2]
    st_d.sb2[`SSR_SB2_FRAME]    = ev_q[1];             // [RULE3]
    st_d.sb2[`SSR_SB2_OVERRUN]  = ev_q[2];             // [RULE4]
    st_d.sb2[`SSR_SB2_RX_OVF]   = ev_q[3];             // [RULE5]
    st_d.sb2[`SSR_SB2_RX_FULL]  = rx_full;             // [RULE6]
    st_d.sb2[`SSR_SB2_RX_NEMPTY] = rx_nempty;          // [RULE6]
    st_d.sb2[`SSR_SB2_TX_NFULL] = tx_nfull;            // [RULE6]
    st_d.sb2[`SSR_SB2_TX_EMPTY] = tx_empty;            // [RULE6]

    // Third byte
    st_d.sb3 = '0;
    st_d.sb3[`SSR_SB3_NO_CTS]   = !rts_out && cts_in;  // [RULE7]
    st_d.sb3[`SSR_SB3_MANUAL]   = ev_q[4];             // [RULE8]
    st_d.sb3[`SSR_SB3_AUTODISC] = st_q.autodisc;       // [RULE9]
    st_d.sb3[`SSR_SB3_BREAK]    = ev_q[5];             // [RULE8]
    st_d.sb3[`SSR_SB3_REMOTE]   = remote_mode;         // [RULE9]
    st_d.sb3[`SSR_SB3_SYNTAX]   = ev_q[6];             // [RULE10]
    st_d.sb3[`SSR_SB3_SW_HS]    = st_q.sw_block;       // [RULE11]
    st_d.sb3[`SSR_SB3_HW_HS]    = hw_hs_block;         // [RULE12]

    // System byte condition, highest priority only
    derr = ev_q[0] || ev_q[1] || ev_q[3];
    cond = sb1_code(st_q.autodisc, ev_q[4], ev_q[5], derr,
                    rx_nempty, tx_nfull, !tx_nfull);   // [RULE22]

    // Enabled conditions: a[2] data error, a[1] break,
    // a[0] autodisconnect, b[3] rx full, b[2] rx not empty, b[1] tx full, b[0] tx empty, c[0] syntax
    any_en = (st_q.ena[2] && derr) ||
             (st_q.ena[1] && ev_q[5]) ||
             (st_q.ena[0] && st_q.autodisc) ||
             (st_q.enb[3] && rx_full) ||
             (st_q.enb[2] && rx_nempty) ||
             (st_q.enb[1] && !tx_nfull) ||
             (st_q.enb[0] && tx_empty) ||
             (st_q.enc[0] && ev_q[6]);                 // [RULE15]
    want = st_q.ena[`SSR_GLOBAL_EN_BIT] &&
           (any_en || ev_q[4]);                        // [RULE14]

    // Status answer stops marking until condition changes
    // The acknowledge holds off marking while the same code stands,
    // so a condition that outlives the status answer stops flagging;
    // a new or a cleared condition re-arms the request.
    if (status_sent) begin                             // [RULE18]
      st_d.srq_ack = 1'b1;
    end else if (cond != st_q.prev_cond) begin
      st_d.srq_ack = 1'b0;
    end
    st_d.prev_cond = cond;
    st_d.srq = want && !st_d.srq_ack;                  // [RULE1]

    // Bit 7 flags a valid code; it is low only with no condition
    st_d.sb1 = {1'b1, st_d.srq, cond};
    if (cond == `SSR_CODE_NONE) begin
      st_d.sb1 = {1'b0, st_d.srq, cond};
    end

    // Asynchronous permission
    if (cmd_ear) begin                                 // [RULE19]
      st_d.async_ok = 1'b1;
    end else if (cmd_universal) begin                  // [RULE20]
      st_d.async_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Message marking and own identify
  // Marking is combinational so the bit rides on the message in the
  // cycle it passes; only data, end and identify frames carry it.
  always_comb begin
    msg_srq_out = msg_srq_in;
    if (msg_valid && st_q.srq &&
        msg_kind != ssr_pkg::SSR_MSG_OTHER) begin
      msg_srq_out = 1'b1;                              // [RULE17]
    end
  end
  // Own identify drops while the controller acknowledges, so each
  // acknowledge answers one request only.
  assign async_idy_req = st_q.srq && st_q.async_ok &&
                         loop_idle && !async_ack;      // [RULE19]

  // Outputs
  // The reserved byte reads as a fixed pattern
  assign autodisconnect_q        = st_q.autodisc;
  assign system_condition_status = st_q.sb1;
  assign buffer_error_status     = st_q.sb2;
  assign line_mode_status        = st_q.sb3;
  assign spare_status            = `SSR_SPARE_RST;     // [RULE13]
  assign request_enable_ctrl_a   = st_q.ena;
  assign request_enable_ctrl_b   = st_q.enb;
  assign request_enable_ctrl_c   = st_q.enc;
endmodule

// ===== src/ssr_consts.svh
// Constants for the status and service-request block.
// Assumes inclusion by bare name from design and bench files.
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
// Status byte 1 field positions and condition codes
`define SSR_SB1_SRQ_BIT      6
`define SSR_SB1_TOP_BIT      7
`define SSR_CODE_NONE        6'h00
`define SSR_CODE_NO_ROOM     6'h05
`define SSR_CODE_KEYBOARD    6'h09
`define SSR_CODE_DEVICE      6'h0a
`define SSR_CODE_DATA_ERR    6'h03
`define SSR_CODE_RDY_SEND    6'h22
`define SSR_CODE_RDY_RECV    6'h21
`define SSR_CODE_NOT_RDY     6'h23
// Status byte 2 bit positions
`define SSR_SB2_PARITY       7
`define SSR_SB2_FRAME        6
`define SSR_SB2_OVERRUN      5
`define SSR_SB2_RX_OVF       4
`define SSR_SB2_RX_FULL      3
`define SSR_SB2_RX_NEMPTY    2
`define SSR_SB2_TX_NFULL     1
`define SSR_SB2_TX_EMPTY     0
// Status byte 3 bit positions
`define SSR_SB3_NO_CTS       7
`define SSR_SB3_MANUAL       6
`define SSR_SB3_AUTODISC     5
`define SSR_SB3_BREAK        4
`define SSR_SB3_REMOTE       3
`define SSR_SB3_SYNTAX       2
`define SSR_SB3_SW_HS        1
`define SSR_SB3_HW_HS        0
// Global enable bit of control register a
`define SSR_GLOBAL_EN_BIT    3
// Enable defaults: switch closed, switch open (five of nine set)
`define SSR_RST_CTRL_A_CLOSED 4'h0
`define SSR_RST_CTRL_B_CLOSED 4'h0
`define SSR_RST_CTRL_C_CLOSED 4'h0
`define SSR_RST_CTRL_A_OPEN   4'hc
`define SSR_RST_CTRL_B_OPEN   4'h6
`define SSR_RST_CTRL_C_OPEN   4'h1
// Reset value of the spare byte
`define SSR_SPARE_RST         8'h00
`endif

// ===== src/ssr_pkg.sv
// Types for the status and service-request block.
// Assumes ssr_consts.svh defines the numbers.
package ssr_pkg;
  typedef enum logic [1:0] {
    SSR_MSG_DATA,
    SSR_MSG_END,
    SSR_MSG_IDY,
    SSR_MSG_OTHER
  } ssr_msg_t;
endpackage

// ===== src/ssr_sticky.sv
// Sticky flag bank: set wins over clear.
// Assumes one clock and active-low asynchronous reset.
`timescale 1ns/1ps
module ssr_sticky (
  input  wire logic       clk,   // Device clock
  input  wire logic       nrst,  // Async reset, low
  input  wire logic [6:0] set,   // Event pulses
  input  wire logic [6:0] clr,   // Clear pulses
  output logic      [6:0] flag_q // Held flags
);
  typedef struct packed {
    logic [6:0] flag;
  } ssr_sticky_st_t;
  ssr_sticky_st_t st_q;
  ssr_sticky_st_t st_d;

  // Set has priority over clear
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < 7; i++) begin
      if (set[i]) begin
        st_d.flag[i] = 1'b1;
      end else if (clr[i]) begin
        st_d.flag[i] = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_q = st_q.flag;
endmodule

// ===== tb/ssr_status_srq_checker.sv
// Port assertions for the status and service-request block.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ssr_status_srq_checker (
  input wire logic              clk,                  // Device clock
  input wire logic              nrst,                 // Reset, low
  input wire logic              rx_full,              // Level
  input wire logic              rx_nempty,            // Level
  input wire logic              tx_nfull,             // Level
  input wire logic              tx_empty,             // Level
  input wire logic              rts_out,              // Level
  input wire logic              cts_in,               // Level
  input wire logic              remote_mode,          // Level
  input wire logic              hw_hs_block,          // Level
  input wire logic              parity_err,           // Pulse
  input wire logic              status_sent,          // Pulse
  input wire logic              msg_valid,            // Message here
  input wire ssr_pkg::ssr_msg_t msg_kind,             // Message class
  input wire logic              msg_srq_in,           // Srq bit in
  input wire logic              msg_srq_out,          // Srq bit out
  input wire logic              loop_idle,            // Idle loop
  input wire logic              async_ack,            // Identify taken
  input wire logic              async_idy_req,        // Own identify
  input wire logic [7:0]        buffer_error_status,  // Byte 2
  input wire logic [7:0]        line_mode_status,     // Byte 3
  input wire logic [7:0]        spare_status,         // Byte 4
  input wire logic [3:0]        request_enable_ctrl_a // Enables a
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // Status answer with no parity event near it
  sequence s_quiet_sent;
    !parity_err ##1 status_sent && !parity_err ##1 !parity_err;
  endsequence
  chk_spare_zero: assert property (
    spare_status == 8'h00) else $error("spare byte not zero");
  chk_parity_set: assert property (
    parity_err |-> ##2 buffer_error_status[7]) else $error("parity lost");
  chk_parity_clear: assert property (
    s_quiet_sent |-> ##1 !buffer_error_status[7])
    else $error("parity not cleared");
  chk_buf_levels: assert property (
    $past(nrst) |-> buffer_error_status[3:0] ==
      $past({rx_full, rx_nempty, tx_nfull, tx_empty}))
    else $error("buffer levels wrong");
  chk_cts_bit: assert property (
    $past(nrst) |-> line_mode_status[7] == $past(!rts_out && cts_in))
    else $error("clear to send bit wrong");
  chk_mode_bits: assert property (
    $past(nrst) |-> {line_mode_status[3], line_mode_status[0]} ==
      $past({remote_mode, hw_hs_block})) else $error("mode bits wrong");
  chk_srq_passthru: assert property (
    msg_srq_in |-> msg_srq_out) else $error("incoming srq dropped");
  chk_other_nomark: assert property (
    !msg_valid || msg_kind == ssr_pkg::SSR_MSG_OTHER |->
      msg_srq_out == msg_srq_in) else $error("wrong message marked");
  chk_global_gate: assert property (
    !request_enable_ctrl_a[3] && !$past(request_enable_ctrl_a[3]) &&
      !$past(request_enable_ctrl_a[3], 2) |-> msg_srq_out == msg_srq_in)
    else $error("marked without global enable");
  chk_async_gate: assert property (
    async_idy_req |-> loop_idle && !async_ack)
    else $error("identify request off idle loop");
endmodule
bind ssr_status_srq ssr_status_srq_checker ssr_status_srq_checker_i (.*);

// ===== tb/ssr_loop_ctl.sv
// Loop controller model: passes messages, takes own identifies.
// Assumes device outputs settle well before the rising edge.
`timescale 1ns/1ps
module ssr_loop_ctl (
  input  wire logic        clk,           // Device clock
  input  wire logic        msg_srq_out,   // Srq bit returned
  input  wire logic        async_idy_req, // Device identify
  output ssr_pkg::ssr_msg_t msg_kind,     // Message class
  output logic             msg_valid,     // Message present
  output logic             msg_srq_in,    // Srq bit sent
  output logic             async_ack      // Identify taken
);
  int acks;
  // Idle outputs
  initial begin
    msg_kind = ssr_pkg::SSR_MSG_OTHER;
    msg_valid = 1'b0;
    msg_srq_in = 1'b0;
    async_ack = 1'b0;
    acks = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Pass one message around and return its srq bit
  task automatic send(input ssr_pkg::ssr_msg_t k, input logic s,
                      output logic r);
    @(negedge clk);
    msg_kind = k;
    msg_valid = 1'b1;
    msg_srq_in = s;
    #4;
    r = msg_srq_out;
    @(negedge clk);
    msg_valid = 1'b0;
    msg_kind = ssr_pkg::SSR_MSG_OTHER;
  endtask
  // Take each own identify like a marked one
  always @(negedge clk) begin
    if (async_idy_req && !async_ack) begin
      async_ack <= 1'b1;
      acks <= acks + 1;
    end else begin
      async_ack <= 1'b0;
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the status and service-request block.
// Assumes the loop controller model and the bound checker.
`timescale 1ns/1ps
`include "ssr_consts.svh"
module tb;
  logic              clk, nrst, sw, mv, si, aa, so, ar, ad, r;
  logic [13:0]       pl;
  logic [8:0]        lv;
  logic [1:0]        sel;
  logic [3:0]        wd, ea, eb, ec;
  logic [7:0]        b1, b2, b3, b4, bs, bx;
  ssr_pkg::ssr_msg_t mk;
  int                fail_count, checks_done, a0;
  int                ix[6] = '{0, 1, 3, 4, 5, 6};
  int                bt[6] = '{7, 6, 4, 6, 4, 2};
  ssr_status_srq ssr_status_srq_i (
    .clk(clk), .nrst(nrst), .default_switch_open(sw),
    .parity_err(pl[0]), .frame_err(pl[1]), .overrun_err(pl[2]),
    .rx_dropped(pl[3]), .manual_request_key(pl[4]), .break_rx(pl[5]),
    .syntax_err(pl[6]), .sw_hs_block(pl[7]), .sw_hs_redef(pl[8]),
    .autodisc_clear(pl[9]), .status_sent(pl[10]), .cmd_ear(pl[11]),
    .cmd_universal(pl[12]), .ctrl_wr(pl[13]), .ctrl_sel(sel),
    .ctrl_wdata(wd), .tx_empty(lv[0]), .tx_nfull(lv[1]),
    .rx_nempty(lv[2]), .rx_full(lv[3]), .rts_out(lv[4]), .cts_in(lv[5]),
    .remote_mode(lv[6]), .hw_hs_block(lv[7]), .loop_idle(lv[8]),
    .msg_valid(mv), .msg_kind(mk), .msg_srq_in(si), .async_ack(aa),
    .msg_srq_out(so), .async_idy_req(ar), .autodisconnect_q(ad),
    .system_condition_status(b1), .buffer_error_status(b2),
    .line_mode_status(b3), .spare_status(b4),
    .request_enable_ctrl_a(ea), .request_enable_ctrl_b(eb),
    .request_enable_ctrl_c(ec));
  ssr_loop_ctl ssr_loop_ctl_i (
    .clk(clk), .msg_srq_out(so), .async_idy_req(ar), .msg_kind(mk),
    .msg_valid(mv), .msg_srq_in(si), .async_ack(aa));
  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50us;
    fail_count++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    pl[i] = 1'b1;
    @(negedge clk);
    pl = '0;
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic do_reset(input logic s);
    sw = s;
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    pl = '0;
    lv = 9'h003;
    sel = 2'h0;
    wd = 4'h0;
    fail_count = 0;
    checks_done = 0;
    do_reset(1'b0);
    chk({ea, eb}, 8'h00);
    chk({4'h0, ec}, 8'h00);
    do_reset(1'b1);
    chk({ea, eb}, {`SSR_RST_CTRL_A_OPEN, `SSR_RST_CTRL_B_OPEN});
    chk({4'h0, ec}, {4'h0, `SSR_RST_CTRL_C_OPEN});
    lv = 9'h0ea;
    settle();
    chk(b2, 8'h0a);
    chk(b3, 8'h89);
    lv = 9'h033;
    settle();
    chk(b2, 8'h03);
    chk(b3, 8'h00);
    for (int k = 0; k < 6; k++) begin
      bx = ix[k] < 4 ? 8'h03 : 8'h00;
      pulse(ix[k]);
      settle();
      bs = ix[k] < 4 ? b2 : b3;
      chk(bs, bx | 8'h01 << bt[k]);
      pulse(10);
      settle();
      bs = ix[k] < 4 ? b2 : b3;
      chk(bs, bx);
    end
    chk(b1, {2'b10, `SSR_CODE_RDY_RECV});
    pulse(0);
    settle();
    chk(b1, {2'b11, `SSR_CODE_DATA_ERR});
    for (int k = 0; k < 4; k++) begin
      ssr_loop_ctl_i.send(ssr_pkg::ssr_msg_t'(k), 1'b0, r);
      chk({7'h00, r}, k < 3 ? 8'h01 : 8'h00);
    end
    pulse(2);
    settle();
    chk({2'b00, b1[5:0]}, {2'b00, `SSR_CODE_NO_ROOM});
    chk({5'h00, ad, b2[5], b3[5]}, 8'h07);
    pulse(9);
    settle();
    chk({2'b00, b1[5:0]}, {2'b00, `SSR_CODE_DATA_ERR});
    pulse(10);
    settle();
    chk({7'h00, b1[6]}, 8'h00);
    ssr_loop_ctl_i.send(ssr_pkg::SSR_MSG_DATA, 1'b0, r);
    chk({7'h00, r}, 8'h00);
    pulse(4);
    settle();
    chk(b1, {2'b11, `SSR_CODE_KEYBOARD});
    pulse(11);
    lv[8] = 1'b1;
    settle();
    chk({7'h00, ssr_loop_ctl_i.acks != 0}, 8'h01);
    pulse(12);
    settle();
    a0 = ssr_loop_ctl_i.acks;
    settle();
    chk({7'h00, ssr_loop_ctl_i.acks == a0}, 8'h01);
    lv[8] = 1'b0;
    pulse(10);
    lv[2] = 1'b1;
    settle();
    ssr_loop_ctl_i.send(ssr_pkg::SSR_MSG_END, 1'b0, r);
    chk({7'h00, r}, 8'h01);
    chk(b1, {2'b11, `SSR_CODE_RDY_SEND});
    pulse(10);
    settle();
    ssr_loop_ctl_i.send(ssr_pkg::SSR_MSG_END, 1'b0, r);
    chk({6'h00, r, b1[6]}, 8'h00);
    lv[2] = 1'b0;
    sel = 2'h0;
    wd = 4'h4;
    pulse(13);
    settle();
    chk({4'h0, ea}, 8'h04);
    sel = 2'h1;
    wd = 4'h9;
    pulse(13);
    sel = 2'h2;
    wd = 4'h0;
    pulse(13);
    settle();
    chk({eb, ec}, 8'h90);
    pulse(0);
    settle();
    ssr_loop_ctl_i.send(ssr_pkg::SSR_MSG_DATA, 1'b0, r);
    chk({6'h00, r, b1[6]}, 8'h00);
    pulse(7);
    settle();
    chk({7'h00, b3[1]}, 8'h01);
    pulse(8);
    settle();
    chk({7'h00, b3[1]}, 8'h00);
    chk(b4, 8'h00);
    end_of_test();
  end
endmodule
